//--- src/i2cc_controller.sv
// I2C controller: SCL timing, clock sync, addressing and bus conditions
// Functional notes
// - Enabled with pin function selected, SCL and SDA drive as open drain.
// - Lower speed: SCL high for high count+1, low for low count+1 clocks.
// - High-time counting begins only once SCL is seen high.
// - SCL pulled low early ends high time; low time then counted fully.
// - High speed uses its own count pair after a lower-speed preamble.
// - High-speed period is (fast high+1) plus (fast low+1) clocks.
// - After START the logic shifts out the address byte from the queue.
// - Seven-bit mode: one queued byte, address plus read/write bit, is sent.
// - Ten-bit mode: prefix byte with R/W 0, then low byte; reads restart.
// - Controller select 1 and begin request give START once bus is free and a byte is queued.
// - Repeat request: finish transaction, repeat START, clear at its begin.
// - Begin request clears itself only after STOP has been sent.
// - End request makes the controller send STOP.
// - Begin plus repeat: START first, repeated START at transaction end.
// - Repeat plus end: only repeated START, then both requests clear.
// - All three: START, then repeated START; end request cleared, ignored.
// - Controller select 0 forces all three requests to zero.
// - Requests, queue data and thresholds may be written at any time.
// - Data writes fill the transmit queue, reads pop the receive queue.
// - SCL stalls low while receive queue is full or transmit queue empty.
`timescale 1ns/1ns
module i2cc_controller import i2cc_pkg::*; #(
    parameter int TX_DEPTH = 8,
    parameter int RX_DEPTH = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [4:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [31:0] rdata,
    input wire logic pinSelect,
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe
);
    localparam int TXAW = $clog2(TX_DEPTH);
    localparam int RXAW = $clog2(RX_DEPTH);

    if (TX_DEPTH < 2 || (TX_DEPTH & (TX_DEPTH - 1)) != 0) begin : g_badTx
        $error("TX_DEPTH must be a power of two, at least 2");
    end
    if (RX_DEPTH < 2 || (RX_DEPTH & (RX_DEPTH - 1)) != 0) begin : g_badRx
        $error("RX_DEPTH must be a power of two, at least 2");
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic enable, ctrlSel, hsSel, tenBit, irxSel;
    logic startReq, repeatReq, stopReq;
    logic [7:0] sclHi, sclLo, fastHi, fastLo, rxCnt;
    i2cc_state_e state;
    logic [7:0] cnt, sh, remain;
    logic [3:0] bitIdx;
    logic sclLow, sdaLow, byteTx, isRead, addrPend, hsActive, nackSeen;
    logic busBusy, sdaPrev;
    logic [2:0] sclSync, sdaSync;
    logic sclS, sdaS;
    logic [7:0] txMem [TX_DEPTH];
    logic [7:0] rxMem [RX_DEPTH];
    logic [TXAW-1:0] txRp, txWp;
    logic [RXAW-1:0] rxRp, rxWp;
    logic [TXAW:0] txCnt;
    logic [RXAW:0] rxCount;

    wire wrCtrl = wrStrobe && addr == OFS_CTRL;
    wire wrReq = wrStrobe && addr == OFS_REQ;
    wire rdData = rdStrobe && addr == OFS_DATA;
    wire nextCtrlSel = wrCtrl ? wdata[CTL_CSEL] : ctrlSel;
    wire txEmpty = txCnt == '0;
    wire txFull = txCnt == (TXAW+1)'(TX_DEPTH);
    wire rxEmpty = rxCount == '0;
    wire rxFull = rxCount == (RXAW+1)'(RX_DEPTH);
    wire [7:0] txHead = txMem[txRp];
    wire txPush = wrStrobe && addr == OFS_DATA && !txFull;
    wire rxPop = rdData && !rxEmpty;

    // Timing pair: fast counts only after the preamble byte
    wire [7:0] curHi = hsActive ? fastHi : sclHi;
    wire [7:0] curLo = hsActive ? fastLo : sclLo;
    wire highPhase = state == ST_BITHI || state == ST_STARTHI ||
                     state == ST_RSHI || state == ST_STOPHI;
    wire [7:0] limit = highPhase ? curHi : curLo;
    wire tDone = cnt == limit;
    // High time ends on its count, or early when SCL is pulled low
    wire hiEnd = state == ST_BITHI && (sclS ? tDone : cnt != 8'h00);
    wire byteEnd = hiEnd && bitIdx == ACK_BIT;
    wire pushRx = byteEnd && !byteTx;
    wire sdaBit = bitIdx == ACK_BIT ? (!byteTx && remain != 8'h00)
                                    : (byteTx && !sh[7]);
    wire wantTx = (addrPend || !isRead) && !txEmpty;
    wire wantRx = !addrPend && isRead && remain != 8'h00 && !rxFull;
    wire txnEnd = !addrPend && (isRead ? remain == 8'h00 : txEmpty);
    wire goRestart = state == ST_HOLD && txnEnd && repeatReq;
    wire goStop = state == ST_HOLD && txnEnd && !repeatReq && stopReq;
    wire stopDone = state == ST_STOPHI && sclS && tDone;
    wire loadAddr = state == ST_STARTHI && sclS && tDone;
    wire popTx = loadAddr || (state == ST_HOLD && wantTx);
    wire canBegin = enable && ctrlSel && startReq && !txEmpty;

    ////////////////////////////////////////////////////////////////////////
    // Register file
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            enable <= 1'b0;
            ctrlSel <= 1'b0;
            hsSel <= 1'b0;
            tenBit <= 1'b0;
            irxSel <= 1'b0;
        end else if (wrCtrl) begin
            enable <= wdata[CTL_EN];
            ctrlSel <= wdata[CTL_CSEL];
            hsSel <= wdata[CTL_HS];
            tenBit <= wdata[CTL_TEN];
            irxSel <= wdata[CTL_IRX];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sclHi <= RST_COUNT;
            sclLo <= RST_COUNT;
            fastHi <= RST_FAST;
            fastLo <= RST_FAST;
            rxCnt <= RST_RXCNT;
        end else if (wrStrobe) begin
            if (addr == OFS_SCLHI) sclHi <= wdata[7:0];
            if (addr == OFS_SCLLO) sclLo <= wdata[7:0];
            if (addr == OFS_HSCLK) begin
                fastHi <= wdata[HS_HI_LSB +: 8];
                fastLo <= wdata[HS_LO_LSB +: 8];
            end
            if (addr == OFS_RXCNT) rxCnt <= wdata[7:0];
        end
    end

    // A software write in the same cycle wins over the hardware clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            startReq <= 1'b0;
            repeatReq <= 1'b0;
            stopReq <= 1'b0;
        end else if (wrReq) begin
            startReq <= nextCtrlSel && wdata[REQ_BEGIN];
            repeatReq <= nextCtrlSel && wdata[REQ_REPEAT];
            stopReq <= nextCtrlSel && wdata[REQ_END];
        end else begin
            startReq <= nextCtrlSel && startReq && !stopDone;
            repeatReq <= nextCtrlSel && repeatReq && !goRestart;
            // Stop is dropped by a restart too
            stopReq <= nextCtrlSel && stopReq && !goRestart && !stopDone;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data queues
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            txRp <= '0;
            txWp <= '0;
            txCnt <= '0;
        end else begin
            if (txPush) txWp <= txWp + 1'b1;
            if (popTx) txRp <= txRp + 1'b1;
            if (txPush && !popTx) txCnt <= txCnt + 1'b1;
            else if (!txPush && popTx) txCnt <= txCnt - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (txPush) txMem[txWp] <= wdata[7:0];
        if (pushRx) rxMem[rxWp] <= sh;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rxRp <= '0;
            rxWp <= '0;
            rxCount <= '0;
        end else begin
            if (pushRx) rxWp <= rxWp + 1'b1;
            if (rxPop) rxRp <= rxRp + 1'b1;
            if (pushRx && !rxPop) rxCount <= rxCount + 1'b1;
            else if (!pushRx && rxPop) rxCount <= rxCount - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port: data stands only in the cycle after the strobe
    wire [7:0] status = {nackSeen, hsActive, busBusy, state != ST_IDLE,
                         rxFull, rxEmpty, txFull, txEmpty};
    logic [31:0] rdMux;
    always_comb begin
        case (addr)
            OFS_CTRL: rdMux = {27'h0000000, irxSel, tenBit, hsSel, ctrlSel,
                               enable};
            OFS_REQ: rdMux = {29'h00000000, stopReq, repeatReq, startReq};
            OFS_SCLHI: rdMux = {24'h000000, sclHi};
            OFS_SCLLO: rdMux = {24'h000000, sclLo};
            OFS_HSCLK: rdMux = {16'h0000, fastLo, fastHi};
            OFS_DATA: rdMux = {24'h000000, rxEmpty ? 8'h00 : rxMem[rxRp]};
            OFS_STAT: rdMux = {24'h000000, status};
            OFS_RXCNT: rdMux = {24'h000000, rxCnt};
            default: rdMux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) rdata <= 32'h00000000;
        else rdata <= rdStrobe ? rdMux : 32'h00000000;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin sampling and bus-free tracking
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sclSync <= 3'h7;
            sdaSync <= 3'h7;
            sclS <= 1'b1;
            sdaS <= 1'b1;
        end else begin
            sclSync <= {sclSync[1:0], sclIn};
            sdaSync <= {sdaSync[1:0], sdaIn};
            if (sclSync[1] == sclSync[2]) sclS <= sclSync[2];
            if (sdaSync[1] == sdaSync[2]) sdaS <= sdaSync[2];
        end
    end

    // START or STOP seen from any controller, ours included
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sdaPrev <= 1'b1;
            busBusy <= 1'b0;
        end else begin
            sdaPrev <= sdaS;
            if (sclS && sdaPrev && !sdaS) busBusy <= 1'b1;
            else if (sclS && !sdaPrev && sdaS) busBusy <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bit engine
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= ST_IDLE;
            cnt <= 8'h00;
            sh <= 8'h00;
            remain <= 8'h00;
            bitIdx <= 4'h0;
            sclLow <= 1'b0;
            sdaLow <= 1'b0;
            byteTx <= 1'b1;
            isRead <= 1'b0;
            addrPend <= 1'b0;
            hsActive <= 1'b0;
            nackSeen <= 1'b0;
        end else if (!enable || !ctrlSel) begin
            state <= ST_IDLE;
            sclLow <= 1'b0;
            sdaLow <= 1'b0;
            hsActive <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    sclLow <= 1'b0;
                    sdaLow <= 1'b0;
                    hsActive <= 1'b0;
                    cnt <= 8'h00;
                    if (canBegin) state <= ST_BUSWAIT;
                end
                // Bus free time equals the low time
                ST_BUSWAIT: begin
                    if (busBusy) cnt <= 8'h00;
                    else if (tDone) begin
                        state <= ST_STARTHI;
                        cnt <= 8'h00;
                        sdaLow <= 1'b1;
                        nackSeen <= 1'b0;
                    end else cnt <= cnt + 8'h01;
                end
                ST_STARTHI: begin
                    if (loadAddr) begin
                        sh <= txHead;
                        byteTx <= 1'b1;
                        isRead <= txHead[0];
                        addrPend <= tenBit && !txHead[0] &&
                                    txHead[7:3] == TEN_PREFIX;
                        remain <= rxCnt;
                        bitIdx <= 4'h0;
                        cnt <= 8'h00;
                        sclLow <= 1'b1;
                        state <= ST_BITLO;
                    end else if (sclS) cnt <= cnt + 8'h01;
                end
                ST_BITLO: begin
                    if (cnt == 8'h00) sdaLow <= sdaBit;
                    if (tDone) begin
                        sclLow <= 1'b0;
                        cnt <= 8'h00;
                        state <= ST_BITHI;
                    end else cnt <= cnt + 8'h01;
                end
                ST_BITHI: begin
                    if (hiEnd) begin
                        if (bitIdx != ACK_BIT) sh <= {sh[6:0], sdaS};
                        else if (byteTx) nackSeen <= nackSeen | sdaS;
                        if (byteEnd && hsSel) hsActive <= 1'b1;
                        bitIdx <= bitIdx + 4'h1;
                        state <= byteEnd ? ST_HOLD : ST_BITLO;
                        sclLow <= 1'b1;
                        cnt <= 8'h00;
                    end else if (sclS) cnt <= cnt + 8'h01;
                end
                // SCL held low until there is something to do
                ST_HOLD: begin
                    sdaLow <= 1'b0;
                    bitIdx <= 4'h0;
                    cnt <= 8'h00;
                    if (popTx) begin
                        sh <= txHead;
                        byteTx <= 1'b1;
                        addrPend <= 1'b0;
                        state <= ST_BITLO;
                    end else if (wantRx) begin
                        byteTx <= 1'b0;
                        remain <= remain - 8'h01;
                        state <= ST_BITLO;
                    end else if (goRestart) begin
                        state <= ST_RSLO;
                    end else if (goStop) begin
                        state <= ST_STOPLO;
                    end
                end
                ST_RSLO: begin
                    if (tDone) begin
                        sclLow <= 1'b0;
                        cnt <= 8'h00;
                        state <= ST_RSHI;
                    end else cnt <= cnt + 8'h01;
                end
                ST_RSHI: begin
                    if (sclS && tDone) begin
                        sdaLow <= 1'b1;
                        cnt <= 8'h00;
                        state <= ST_STARTHI;
                    end else if (sclS) cnt <= cnt + 8'h01;
                end
                ST_STOPLO: begin
                    sdaLow <= 1'b1;
                    if (tDone) begin
                        sclLow <= 1'b0;
                        cnt <= 8'h00;
                        state <= ST_STOPHI;
                    end else cnt <= cnt + 8'h01;
                end
                ST_STOPHI: begin
                    if (stopDone) begin
                        sdaLow <= 1'b0;
                        state <= ST_IDLE;
                    end else if (sclS) cnt <= cnt + 8'h01;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Pads only ever pull low; the pull-up gives the high level
    assign sclOut = 1'b0;
    assign sdaOut = 1'b0;
    assign sclOe = enable && pinSelect && sclLow;
    assign sdaOe = enable && pinSelect && sdaLow;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_od_pads;
        @(posedge clk) disable iff (reset)
        (sclOe || sdaOe) |-> enable && pinSelect && !sclOut && !sdaOut;
    endproperty
    a_od_pads: assert property (p_od_pads)
        else $error("pad driven while not enabled or not open drain");

    property p_low_time;
        @(posedge clk) disable iff (reset)
        (state == ST_BITLO && cnt < limit && enable && ctrlSel) |=>
            state == ST_BITLO && sclOe == $past(sclOe);
    endproperty
    a_low_time: assert property (p_low_time)
        else $error("SCL low phase ended before its count");

    property p_wait_high;
        @(posedge clk) disable iff (reset)
        (state == ST_BITHI && !sclS && cnt == 8'h00 && enable && ctrlSel)
            |=> state == ST_BITHI && cnt == 8'h00;
    endproperty
    a_wait_high: assert property (p_wait_high)
        else $error("high count started while SCL still low");

    property p_early_low;
        @(posedge clk) disable iff (reset)
        (state == ST_BITHI && !sclS && cnt != 8'h00 && enable && ctrlSel)
            |=> sclLow && state != ST_BITHI;
    endproperty
    a_early_low: assert property (p_early_low)
        else $error("SCL pulled low early did not start low phase");

    property p_force_clear;
        @(posedge clk) disable iff (reset)
        !ctrlSel |-> !startReq && !repeatReq && !stopReq;
    endproperty
    a_force_clear: assert property (p_force_clear)
        else $error("request bit set while controller select is off");

    property p_restart_wins;
        @(posedge clk) disable iff (reset)
        (goRestart && enable && ctrlSel && !wrReq) |=>
            state == ST_RSLO && !repeatReq && !stopReq;
    endproperty
    a_restart_wins: assert property (p_restart_wins)
        else $error("restart did not win or requests not cleared");

    property p_start_clear;
        @(posedge clk) disable iff (reset)
        ($fell(startReq) && !$past(wrReq) && $past(ctrlSel)) |->
            $past(state) == ST_STOPHI && state == ST_IDLE;
    endproperty
    a_start_clear: assert property (p_start_clear)
        else $error("begin request cleared before STOP sent");

    property p_stall;
        @(posedge clk) disable iff (reset)
        (state == ST_HOLD && !isRead && txEmpty && !repeatReq && !stopReq
         && !addrPend && enable && ctrlSel && !txPush) |=>
            state == ST_HOLD && sclLow;
    endproperty
    a_stall: assert property (p_stall)
        else $error("SCL not stalled on empty transmit queue");

    property p_bus_free;
        @(posedge clk) disable iff (reset)
        (state == ST_BUSWAIT && busBusy && enable && ctrlSel) |=>
            state == ST_BUSWAIT && cnt == 8'h00;
    endproperty
    a_bus_free: assert property (p_bus_free)
        else $error("START attempted while bus busy");
endmodule : i2cc_controller

//--- src/i2cc_pkg.sv
// Shared constants and types of the I2C controller clock and conditions block
package i2cc_pkg;
    // Register byte offsets
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_REQ = 5'h04;
    localparam logic [4:0] OFS_SCLHI = 5'h08;
    localparam logic [4:0] OFS_SCLLO = 5'h0C;
    localparam logic [4:0] OFS_HSCLK = 5'h10;
    localparam logic [4:0] OFS_DATA = 5'h14;
    localparam logic [4:0] OFS_STAT = 5'h18;
    localparam logic [4:0] OFS_RXCNT = 5'h1C;
    // Control register fields
    localparam int CTL_EN = 0;
    localparam int CTL_CSEL = 1;
    localparam int CTL_HS = 2;
    localparam int CTL_TEN = 3;
    localparam int CTL_IRX = 4;
    // Request register fields
    localparam int REQ_BEGIN = 0;
    localparam int REQ_REPEAT = 1;
    localparam int REQ_END = 2;
    // Fast clock register fields: high count low byte, low count next byte
    localparam int HS_HI_LSB = 0;
    localparam int HS_LO_LSB = 8;
    // Reset values
    localparam logic [7:0] RST_COUNT = 8'hFF;
    localparam logic [7:0] RST_FAST = 8'h0F;
    localparam logic [7:0] RST_RXCNT = 8'h01;
    // First byte of a ten-bit address carries this prefix
    localparam logic [4:0] TEN_PREFIX = 5'h1E;
    localparam logic [3:0] ACK_BIT = 4'h8;

    typedef enum logic [3:0] {
        ST_IDLE, ST_BUSWAIT, ST_STARTHI, ST_BITLO, ST_BITHI, ST_HOLD,
        ST_RSLO, ST_RSHI, ST_STOPLO, ST_STOPHI
    } i2cc_state_e;
endpackage : i2cc_pkg

//--- test/i2cc_target_model.sv
// Behavioural I2C target: acknowledges every byte, may stretch SCL
`timescale 1ns/1ns
module i2cc_target_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic scl,
    input wire logic sda,
    input wire logic stretch,
    output logic sclLow,
    output logic sdaLow,
    output logic [7:0] lastByte,
    output logic [7:0] nStart,
    output logic [7:0] nStop
);
    logic sP;
    logic dP;
    logic [3:0] bitCnt;
    logic [3:0] hold;
    logic [7:0] shifter;
    // Holding SCL past the controller's low time tests its clock sync
    assign sclLow = hold != 4'h0;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sP <= 1'b1;
            dP <= 1'b1;
            bitCnt <= 4'h0;
            hold <= 4'h0;
            shifter <= 8'h00;
            lastByte <= 8'h00;
            nStart <= 8'h00;
            nStop <= 8'h00;
            sdaLow <= 1'b0;
        end else begin
            sP <= scl;
            dP <= sda;
            if (hold != 4'h0) hold <= hold - 4'h1;
            if (scl && sP && dP && !sda) begin
                nStart <= nStart + 8'h01;
                bitCnt <= 4'h0;
            end else if (scl && sP && !dP && sda) begin
                nStop <= nStop + 8'h01;
            end else if (scl && !sP && bitCnt < 4'h8) begin
                shifter <= {shifter[6:0], sda};
                bitCnt <= bitCnt + 4'h1;
                if (bitCnt == 4'h7) lastByte <= {shifter[6:0], sda};
            end else if (!scl && sP) begin
                hold <= stretch ? 4'h6 : 4'h0;
                if (bitCnt == 4'h8) begin
                    sdaLow <= 1'b1;
                    bitCnt <= 4'h9;
                end else if (bitCnt == 4'h9) begin
                    sdaLow <= 1'b0;
                    bitCnt <= 4'h0;
                end
            end
        end
    end
endmodule : i2cc_target_model

//--- test/tb.sv
// Self-checking bench of the I2C controller with a target model
`timescale 1ns/1ns
module tb import i2cc_pkg::*; ;
    logic clk = 0, reset = 1, wrStrobe = 0, rdStrobe = 0, stretch = 0;
    logic [4:0] addr = '0;
    logic [31:0] wdata = '0, rdata, d;
    logic sclOe, sdaOe, sclOut, sdaOut, tScl, tSda;
    logic [7:0] lastByte, nStart, nStop;
    wire scl = !(sclOe || tScl);
    wire sda = !(sdaOe || tSda);
    int miscompares = 0, nCompared = 0;
    i2cc_controller i2cc_controller_i (.clk(clk), .reset(reset),
        .addr(addr), .wdata(wdata), .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe), .rdata(rdata), .pinSelect(1'b1), .sclIn(scl),
        .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaOut),
        .sdaOe(sdaOe));
    i2cc_target_model i2cc_target_model_i (.clk(clk), .reset(reset),
        .scl(scl), .sda(sda), .stretch(stretch), .sclLow(tScl),
        .sdaLow(tSda), .lastByte(lastByte), .nStart(nStart), .nStop(nStop));
    initial begin
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        @(posedge clk) {addr, wdata, wrStrobe} <= {a, v, 1'b1};
        @(posedge clk) wrStrobe <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [31:0] v);
        @(posedge clk) {addr, rdStrobe} <= {a, 1'b1};
        @(posedge clk) rdStrobe <= 1'b0;
        #1 v = rdata;
    endtask : rd
    // Waits for SCL held low past any bit phase, or for a quiet bus
    task automatic settle(input logic idle);
        int n;
        int run;
        run = 0;
        for (n = 0; n < 5000 && run < 40; n++) begin
            @(posedge clk) #1;
            run = (idle ? !(sclOe || sdaOe) : sclOe) && n > 20 ? run + 1 : 0;
        end
    endtask : settle
    task automatic report_and_stop();
        $display("compared %0d mismatched %0d", nCompared, miscompares);
        if (miscompares == 0 && nCompared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////
    task automatic txn(input int k);
        logic [7:0] lo, hi, a1, a2, s0, b0;
        int n;
        lo = 8'($urandom_range(1, 7));
        hi = 8'($urandom_range(1, 7));
        a1 = {7'($urandom), 1'b0};
        a2 = {7'($urandom), 1'b0};
        s0 = nStop;
        b0 = nStart;
        stretch <= k[0];
        wr(OFS_CTRL, 32'h0);
        wr(OFS_SCLHI, {24'h0, hi});
        wr(OFS_SCLLO, {24'h0, lo});
        wr(OFS_CTRL, k == 2 ? 32'h7 : 32'h3);
        wr(OFS_DATA, {24'h0, a1});
        wr(OFS_REQ, 32'h1);
        for (n = 0; n < 3000 && sclOe !== 1'b1; n++) @(posedge clk) #1;
        for (n = 0; n < 300 && sclOe === 1'b1; n++) @(posedge clk) #1;
        chk(n, lo + 1);
        settle(1'b0);
        chk(lastByte, a1);
        rd(OFS_REQ, d);
        chk(d, 32'h1);
        wr(OFS_REQ, 32'h7);
        wr(OFS_DATA, {24'h0, a2});
        settle(1'b0);
        chk(lastByte, a2);
        chk(nStart, b0 + 8'h2);
        chk(nStop, s0);
        rd(OFS_REQ, d);
        chk(d, 32'h1);
        rd(OFS_STAT, d);
        chk(d, (k == 2) ? 32'h75 : 32'h35);
        // Begin kept set so its own clear after STOP is what gets checked
        wr(OFS_REQ, 32'h5);
        settle(1'b1);
        chk(nStop, s0 + 8'h1);
        rd(OFS_REQ, d);
        chk(d, 32'h0);
        rd(OFS_STAT, d);
        chk(d, 32'h05);
        $display("transaction %0d done", k);
    endtask : txn
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [4:0] ofs [7];
        logic [31:0] rv [7];
        ofs = '{OFS_CTRL, OFS_REQ, OFS_SCLHI, OFS_SCLLO, OFS_HSCLK, OFS_RXCNT,
            5'h02};
        rv = '{32'h0, 32'h0, {24'h0, RST_COUNT}, {24'h0, RST_COUNT},
            {16'h0, RST_FAST, RST_FAST}, {24'h0, RST_RXCNT}, 32'h0};
        void'($urandom(91));
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        foreach (ofs[i]) begin
            rd(ofs[i], d);
            chk(d, rv[i]);
        end
        $display("reset values done");
        wr(OFS_CTRL, 32'h1);
        wr(OFS_REQ, 32'h7);
        rd(OFS_REQ, d);
        chk(d, 32'h0);
        chk({sclOe, sdaOe}, 2'b00);
        chk({sclOut, sdaOut}, 2'b00);
        $display("forced clear done");
        for (int k = 0; k < 3; k++) txn(k);
        report_and_stop();
    end
    initial begin
        #(10 * 80000);
        miscompares++;
        report_and_stop();
    end
endmodule : tb
